// ==== pkg/ccfg_consts.svh ====
// offsets, field positions and reset values of the configuration decoder
// assumes inclusion by bare name from the package and the design file
`ifndef CCFG_CONSTS_SVH
`define CCFG_CONSTS_SVH
// -----------------------------------------------------------------
// byte addresses
// -----------------------------------------------------------------
`define CCFG_OSC_CFG_ADDR 22'h300000
`define CCFG_MON_CFG_ADDR 22'h300001
`define CCFG_RST_CFG_ADDR 22'h300002
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CCFG_PWRUP_HI 6
`define CCFG_PWRUP_LO 4
`define CCFG_EXTMODE_HI 2
`define CCFG_EXTMODE_LO 0
`define CCFG_SEC_MON_BIT 7
`define CCFG_PRI_MON_BIT 6
`define CCFG_FSM_EN_BIT 5
`define CCFG_SWITCH_BIT 3
`define CCFG_ONESHOT_BIT 1
`define CCFG_CLOCK_OUTPUT_FUNCTION_BIT 0
`define CCFG_BOR_HI 7
`define CCFG_BOR_LO 6
// -----------------------------------------------------------------
// reset values of the bytes (unimplemented bits read as one)
// -----------------------------------------------------------------
`define CCFG_OSC_CFG_RST 8'hff
`define CCFG_MON_CFG_RST 8'hff
`define CCFG_RST_CFG_RST 8'h7f
// fast internal oscillator frequencies and dividers, coded
`define CCFG_FREQ_4MHZ 4'h2
`define CCFG_FREQ_64MHZ 4'h8
`define CCFG_DIV_4 4'h2
`define CCFG_DIV_1 4'h0
`define CCFG_SYSCLK_OUT_DIV 2'h3
`endif

// ==== pkg/ccfg_pkg.sv ====
// types for the configuration decoder
// assumes the constants header sits beside it
package ccfg_pkg;
   `include "ccfg_consts.svh"
   // power-up oscillator codes
   typedef enum logic [2:0] {
      CCFG_OSC_FAST_64 = 3'h0,
      CCFG_OSC_RSVD1 = 3'h1,
      CCFG_OSC_EXT_PLL = 3'h2,
      CCFG_OSC_RSVD3 = 3'h3,
      CCFG_OSC_SECONDARY = 3'h4,
      CCFG_OSC_SLOW_INT = 3'h5,
      CCFG_OSC_FAST_INT = 3'h6,
      CCFG_OSC_EXT = 3'h7
   } ccfg_osc_t;
   // external oscillator modes
   typedef enum logic [2:0] {
      CCFG_EXT_WATCH_XTAL = 3'h0,
      CCFG_EXT_MED_XTAL = 3'h1,
      CCFG_EXT_FAST_XTAL = 3'h2,
      CCFG_EXT_RSVD = 3'h3,
      CCFG_EXT_OFF = 3'h4,
      CCFG_EXT_CLK_LOW = 3'h5,
      CCFG_EXT_CLK_MID = 3'h6,
      CCFG_EXT_CLK_HIGH = 3'h7
   } ccfg_ext_t;
   // brown-out modes
   typedef enum logic [1:0] {
      CCFG_BOR_OFF = 2'h0,
      CCFG_BOR_SOFT = 2'h1,
      CCFG_BOR_RUN = 2'h2,
      CCFG_BOR_ON = 2'h3
   } ccfg_bor_t;
   // priority-lock one-shot tracking
   typedef enum {
      CCFG_LK_FREE,
      CCFG_LK_CLEARED,
      CCFG_LK_FROZEN
   } ccfg_lock_t;
endpackage

// ==== rtl/ccfg_decoder.sv ====
// configuration byte decoder: clock, monitor, lock, clock-out, brown-out
// assumes the byte store lives outside; bytes arrive on cfg_*_byte pins
// and are synchronised here; write ports come from the core clock domain
`timescale 1ns/1ps
`include "ccfg_consts.svh"

// How it works
// - power-up field bits 6:4 of byte one seeds the current oscillator.
// - code 110 gives 4 MHz div 4, 000 gives 64 MHz div 1; selections 110.
// - 111 external, 101 slow internal, 100 secondary, 010 external PLL.
// - mode bits 2:0: 111 high, 110 mid, 101 low external clock.
// - 100 off, 011 reserved, 010 fast, 001 medium, 000 watch crystal.
// - byte two bit 7 enables secondary monitor: fail sets status and flag.
// - byte two bit 6 enables primary monitor: fail sets status and flag.
// - byte two bit 5 is the overall fail-safe monitor enable.
// - byte two bit 3 allows writes of new oscillator and divider.
// - byte two bit 1 limits priority lock to one clear-then-set cycle.
// - clock-output enable is ignored in all three crystal modes.
// - otherwise low drives the pin with system clock over four.
// - brown-out field bits 7:6 of byte three: on, run, software, off.
// - whenever brown-out is enabled the trip comes from voltage select.
module ccfg_decoder
   import ccfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] cfg_osc_byte,
   input wire logic [7:0] cfg_mon_byte,
   input wire logic [7:0] cfg_rst_byte,
   input wire logic [1:0] brownout_voltage_select,
   input wire logic secondary_fail_event,
   input wire logic primary_fail_event,
   input wire logic sleep_active,
   input wire logic software_brownout_enable,
   input wire logic sw_new_osc_wr,
   input wire logic [2:0] sw_new_osc_data,
   input wire logic sw_new_div_wr,
   input wire logic [3:0] sw_new_div_data,
   input wire logic sw_lock_clear,
   input wire logic sw_lock_set,
   input wire logic sw_fail_clear,
   output logic [2:0] current_osc_selection,
   output logic [2:0] new_osc_selection,
   output logic [3:0] new_divider_selection,
   output logic [3:0] fast_internal_frequency,
   output logic [2:0] external_osc_mode,
   output logic pll_enable,
   output logic ext_osc_enable,
   output logic osc_cfg_reserved,
   output logic fail_safe_monitor_enable,
   output logic secondary_fail_status,
   output logic primary_fail_status,
   output logic osc_fail_interrupt_flag,
   output logic clock_switch_allow,
   output logic priority_lock_bit,
   output logic second_oscillator_pin_out,
   output logic second_oscillator_pin_oe,
   output logic brownout_active,
   output logic [1:0] brownout_trip_select
);

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   logic [25:0] sync1_q;
   logic [25:0] sync2_q;
   logic [25:0] raw_in;
   assign raw_in = {cfg_osc_byte, cfg_mon_byte, cfg_rst_byte,
                    secondary_fail_event, primary_fail_event};
   logic [1:0] misc1_q;
   logic [1:0] misc2_q;
   logic [3:0] bv1_q;

   // two stages for every pin-level input; no reset, so the stages stay
   // full while reset is held and the whole capture window sees real bytes
   always_ff @(posedge core_clk) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      misc1_q <= {sleep_active, software_brownout_enable};
      misc2_q <= misc1_q;
      bv1_q <= {brownout_voltage_select, bv1_q[3:2]};
   end

   // -----------------------------------------------------------------
   // configuration capture
   // -----------------------------------------------------------------
   logic [7:0] osc_cfg_q;
   logic [7:0] mon_cfg_q;
   logic [7:0] rst_cfg_q;
   logic [1:0] brownout_voltage_select_q;
   logic [1:0] cap_cnt_q;
   logic capture_busy;
   assign capture_busy = (cap_cnt_q != 2'h0);

   // sample at reset
   // bytes are captured after the synchroniser has refilled, then frozen;
   // a mid-run change on the pins is ignored until the next reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cap_cnt_q <= 2'h3;
         osc_cfg_q <= `CCFG_OSC_CFG_RST;
         mon_cfg_q <= `CCFG_MON_CFG_RST;
         rst_cfg_q <= `CCFG_RST_CFG_RST;
         brownout_voltage_select_q <= 2'h3;
      end else if (capture_busy) begin
         cap_cnt_q <= cap_cnt_q - 2'h1;
         osc_cfg_q <= sync2_q[25:18];
         mon_cfg_q <= sync2_q[17:10];
         rst_cfg_q <= sync2_q[9:2];
         brownout_voltage_select_q <= bv1_q[1:0];
      end
   end

   // -----------------------------------------------------------------
   // field decode
   // -----------------------------------------------------------------
   ccfg_osc_t pwrup_sel;
   ccfg_ext_t ext_sel;
   ccfg_bor_t bor_sel;
   assign pwrup_sel = ccfg_osc_t'(osc_cfg_q[`CCFG_PWRUP_HI:`CCFG_PWRUP_LO]);
   assign ext_sel = ccfg_ext_t'(osc_cfg_q[`CCFG_EXTMODE_HI:`CCFG_EXTMODE_LO]);
   assign bor_sel = ccfg_bor_t'(rst_cfg_q[`CCFG_BOR_HI:`CCFG_BOR_LO]);

   function automatic logic is_crystal(input ccfg_ext_t m);
      is_crystal = (m == CCFG_EXT_FAST_XTAL) || (m == CCFG_EXT_MED_XTAL) ||
                   (m == CCFG_EXT_WATCH_XTAL);
   endfunction

   logic ext_used;
   logic rsvd_d;
   logic [2:0] seed_osc;
   logic [3:0] seed_div;
   logic [3:0] seed_freq;
   always_comb begin
      seed_osc = pwrup_sel;
      seed_div = `CCFG_DIV_1;
      seed_freq = `CCFG_FREQ_4MHZ;
      ext_used = 1'b0;
      rsvd_d = 1'b0;
      case (pwrup_sel)
         CCFG_OSC_FAST_INT: begin
            seed_div = `CCFG_DIV_4;
         end
         CCFG_OSC_FAST_64: begin
            seed_osc = CCFG_OSC_FAST_INT;
            seed_freq = `CCFG_FREQ_64MHZ;
         end
         CCFG_OSC_EXT, CCFG_OSC_EXT_PLL: begin
            ext_used = 1'b1;
         end
         CCFG_OSC_SLOW_INT, CCFG_OSC_SECONDARY: begin
            ext_used = 1'b0;
         end
         default: begin
            rsvd_d = 1'b1;
         end
      endcase
      if (ext_sel == CCFG_EXT_RSVD) begin
         rsvd_d = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // clock selection and software switching
   // -----------------------------------------------------------------
   logic [2:0] cur_osc_q;
   logic [2:0] new_osc_q;
   logic [3:0] new_div_q;
   logic switch_ok;
   assign switch_ok = mon_cfg_q[`CCFG_SWITCH_BIT] && !capture_busy;

   // selections follow the seed until capture ends, then software only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cur_osc_q <= 3'h7;
         new_osc_q <= 3'h7;
         new_div_q <= 4'h0;
      end else if (capture_busy) begin
         cur_osc_q <= seed_osc;
         new_osc_q <= seed_osc;
         new_div_q <= seed_div;
      end else begin
         if (sw_new_osc_wr && switch_ok) begin
            new_osc_q <= sw_new_osc_data;
         end
         if (sw_new_div_wr && switch_ok) begin
            new_div_q <= sw_new_div_data;
         end
      end
   end

   // -----------------------------------------------------------------
   // fail-safe monitor
   // -----------------------------------------------------------------
   logic sec_fail_q;
   logic pri_fail_q;
   logic fail_flag_q;
   logic sec_hit;
   logic pri_hit;
   assign sec_hit = sync2_q[1] && mon_cfg_q[`CCFG_FSM_EN_BIT] &&
                    mon_cfg_q[`CCFG_SEC_MON_BIT] && !capture_busy;
   assign pri_hit = sync2_q[0] && mon_cfg_q[`CCFG_FSM_EN_BIT] &&
                    mon_cfg_q[`CCFG_PRI_MON_BIT] && !capture_busy;

   // sticky; a failure in the clearing cycle wins over the clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sec_fail_q <= 1'b0;
         pri_fail_q <= 1'b0;
         fail_flag_q <= 1'b0;
      end else begin
         sec_fail_q <= sec_hit || (sec_fail_q && !sw_fail_clear);
         pri_fail_q <= pri_hit || (pri_fail_q && !sw_fail_clear);
         fail_flag_q <= sec_hit || pri_hit || (fail_flag_q && !sw_fail_clear);
      end
   end

   // -----------------------------------------------------------------
   // priority lock
   // -----------------------------------------------------------------
   ccfg_lock_t lk_q;
   logic lock_q;

   // one-shot lock
   // unlocked at reset; with the one-shot option a single clear then set
   // freezes it, otherwise it toggles as often as software asks
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lk_q <= CCFG_LK_FREE;
         lock_q <= 1'b0;
      end else if (!capture_busy) begin
         case (lk_q)
            CCFG_LK_FREE: begin
               if (sw_lock_set) begin
                  lock_q <= 1'b1;
               end else if (sw_lock_clear) begin
                  lock_q <= 1'b0;
                  if (mon_cfg_q[`CCFG_ONESHOT_BIT]) begin
                     lk_q <= CCFG_LK_CLEARED;
                  end
               end
            end
            CCFG_LK_CLEARED: begin
               if (sw_lock_set) begin
                  lock_q <= 1'b1;
                  lk_q <= CCFG_LK_FROZEN;
               end
            end
            CCFG_LK_FROZEN: begin
               lock_q <= 1'b1;
            end
            default: begin
               lk_q <= CCFG_LK_FREE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // clock output pin
   // -----------------------------------------------------------------
   logic [1:0] div_cnt_q;
   logic clk_out_q;
   logic clk_out_oe_q;
   logic clk_out_on;
   assign clk_out_on = !is_crystal(ext_sel) &&
                       !mon_cfg_q[`CCFG_CLOCK_OUTPUT_FUNCTION_BIT] && !capture_busy;

   // system clock over four: high for two cycles, low for two
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_cnt_q <= 2'h0;
         clk_out_q <= 1'b0;
         clk_out_oe_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_q + 2'h1;
         clk_out_q <= clk_out_on && div_cnt_q[1];
         clk_out_oe_q <= clk_out_on;
      end
   end

   // -----------------------------------------------------------------
   // brown-out
   // -----------------------------------------------------------------
   logic bor_on_d;
   logic bor_q;
   always_comb begin
      case (bor_sel)
         CCFG_BOR_ON: bor_on_d = 1'b1;
         CCFG_BOR_RUN: bor_on_d = !misc2_q[1];
         CCFG_BOR_SOFT: bor_on_d = misc2_q[0];
         default: bor_on_d = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bor_q <= 1'b0;
      end else begin
         bor_q <= bor_on_d && !capture_busy;
      end
   end

   // -----------------------------------------------------------------
   // registered status outputs
   // -----------------------------------------------------------------
   logic [3:0] freq_q;
   logic ext_en_q;
   logic pll_q;
   logic rsvd_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         freq_q <= 4'h0;
         ext_en_q <= 1'b0;
         pll_q <= 1'b0;
         rsvd_q <= 1'b0;
      end else begin
         freq_q <= seed_freq;
         ext_en_q <= ext_used && (ext_sel != CCFG_EXT_OFF);
         pll_q <= (pwrup_sel == CCFG_OSC_EXT_PLL);
         rsvd_q <= rsvd_d;
      end
   end

   assign current_osc_selection = cur_osc_q;
   assign new_osc_selection = new_osc_q;
   assign new_divider_selection = new_div_q;
   assign fast_internal_frequency = freq_q;
   assign external_osc_mode = osc_cfg_q[`CCFG_EXTMODE_HI:`CCFG_EXTMODE_LO];
   assign pll_enable = pll_q;
   assign ext_osc_enable = ext_en_q;
   assign osc_cfg_reserved = rsvd_q;
   assign fail_safe_monitor_enable = mon_cfg_q[`CCFG_FSM_EN_BIT];
   assign secondary_fail_status = sec_fail_q;
   assign primary_fail_status = pri_fail_q;
   assign osc_fail_interrupt_flag = fail_flag_q;
   assign clock_switch_allow = mon_cfg_q[`CCFG_SWITCH_BIT];
   assign priority_lock_bit = lock_q;
   assign second_oscillator_pin_out = clk_out_q;
   assign second_oscillator_pin_oe = clk_out_oe_q;
   assign brownout_active = bor_q;
   assign brownout_trip_select = brownout_voltage_select_q;

endmodule

// ==== tb/ccfg_decoder_assertions.sv ====
// checker for the configuration decoder, bound onto its ports
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module ccfg_decoder_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] cfg_mon_byte,
   input wire logic [7:0] cfg_rst_byte,
   input wire logic secondary_fail_event,
   input wire logic sw_new_osc_wr,
   input wire logic [2:0] sw_new_osc_data,
   input wire logic sw_lock_clear,
   input wire logic sw_lock_set,
   input wire logic [2:0] current_osc_selection,
   input wire logic [2:0] new_osc_selection,
   input wire logic [3:0] new_divider_selection,
   input wire logic [2:0] external_osc_mode,
   input wire logic fail_safe_monitor_enable,
   input wire logic secondary_fail_status,
   input wire logic osc_fail_interrupt_flag,
   input wire logic clock_switch_allow,
   input wire logic priority_lock_bit,
   input wire logic second_oscillator_pin_out,
   input wire logic second_oscillator_pin_oe,
   input wire logic brownout_active
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------
   // helper state
   // ----------------------------------------------------------
   logic [2:0] age_q;
   logic cleared_q;
   wire done = (age_q == 3'h7);
   // age saturates well past the capture window, so checks skip it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         age_q <= 3'h0;
         cleared_q <= 1'b0;
      end else begin
         if (!done)
            age_q <= age_q + 3'h1;
         if (done && sw_lock_clear && !sw_lock_set)
            cleared_q <= 1'b1;
      end
   end
   // ----------------------------------------------------------
   // sequences
   // ----------------------------------------------------------
   sequence sec_hold_s;
      secondary_fail_event [*3];
   endsequence
   sequence clk_wave_s;
      second_oscillator_pin_out [*2] ##1 !second_oscillator_pin_out [*2];
   endsequence
   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   sel_hold_a: assert property (done |-> $stable(current_osc_selection) &&
      $stable(external_osc_mode) && $stable(clock_switch_allow))
      else $error("decoded setting moved while running");
   sw_write_a: assert property (done && sw_new_osc_wr && clock_switch_allow
      |=> new_osc_selection == $past(sw_new_osc_data))
      else $error("allowed oscillator write not taken");
   sw_block_a: assert property (done && !clock_switch_allow |=>
      $stable(new_osc_selection) && $stable(new_divider_selection))
      else $error("blocked write changed a selection");
   sec_fail_a: assert property (done && cfg_mon_byte[7] && cfg_mon_byte[5]
      && $rose(secondary_fail_event) ##0 sec_hold_s
      |=> secondary_fail_status && osc_fail_interrupt_flag)
      else $error("secondary failure not flagged in time");
   mon_off_a: assert property (done && !fail_safe_monitor_enable |->
      !secondary_fail_status && !osc_fail_interrupt_flag)
      else $error("disabled monitor raised a flag");
   lock_set_a: assert property (done && sw_lock_set |=> priority_lock_bit)
      else $error("lock set not taken");
   lock_frozen_a: assert property (cfg_mon_byte[1] && cleared_q &&
      priority_lock_bit |=> priority_lock_bit)
      else $error("one-shot lock reopened");
   xtal_oe_a: assert property (done && external_osc_mode < 3'h3 |->
      !second_oscillator_pin_oe)
      else $error("clock out driven in crystal mode");
   clk_out_a: assert property (done && second_oscillator_pin_oe &&
      $rose(second_oscillator_pin_out) |-> clk_wave_s)
      else $error("clock out is not a divide by four");
   bor_on_a: assert property (done && cfg_rst_byte[7:6] == 2'h3 |->
      brownout_active) else $error("brown-out not always on");
   bor_off_a: assert property (done && cfg_rst_byte[7:6] == 2'h0 |->
      !brownout_active) else $error("brown-out on while disabled");
endmodule
bind ccfg_decoder ccfg_decoder_assertions u_chk (.core_clk, .rst_n,
   .cfg_mon_byte, .cfg_rst_byte, .secondary_fail_event, .sw_new_osc_wr,
   .sw_new_osc_data, .sw_lock_clear, .sw_lock_set, .current_osc_selection,
   .new_osc_selection, .new_divider_selection, .external_osc_mode,
   .fail_safe_monitor_enable, .secondary_fail_status,
   .osc_fail_interrupt_flag, .clock_switch_allow, .priority_lock_bit,
   .second_oscillator_pin_out, .second_oscillator_pin_oe, .brownout_active);

// ==== tb/ccfg_decoder_tb_top.sv ====
// self-checking bench for the configuration decoder
// assumes the decoder and its checker are compiled before it
`timescale 1ns/1ps
`include "ccfg_consts.svh"
module ccfg_decoder_tb_top;
   logic core_clk, rst_n, secondary_fail_event, primary_fail_event;
   logic sleep_active, software_brownout_enable, sw_new_osc_wr;
   logic sw_new_div_wr, sw_lock_clear, sw_lock_set, sw_fail_clear;
   logic [7:0] cfg_osc_byte, cfg_mon_byte, cfg_rst_byte;
   logic [1:0] brownout_voltage_select, brownout_trip_select;
   logic [2:0] sw_new_osc_data, current_osc_selection, new_osc_selection;
   logic [2:0] external_osc_mode;
   logic [3:0] sw_new_div_data, new_divider_selection, fast_internal_frequency;
   logic pll_enable, ext_osc_enable, osc_cfg_reserved, fail_safe_monitor_enable;
   logic secondary_fail_status, primary_fail_status, osc_fail_interrupt_flag;
   logic clock_switch_allow, priority_lock_bit, brownout_active;
   logic second_oscillator_pin_out, second_oscillator_pin_oe;
   int mismatches, compares;
   ccfg_decoder u_ccfg_decoder (.core_clk, .rst_n, .cfg_osc_byte,
      .cfg_mon_byte, .cfg_rst_byte, .brownout_voltage_select,
      .secondary_fail_event, .primary_fail_event, .sleep_active,
      .software_brownout_enable, .sw_new_osc_wr, .sw_new_osc_data,
      .sw_new_div_wr, .sw_new_div_data, .sw_lock_clear, .sw_lock_set,
      .sw_fail_clear, .current_osc_selection, .new_osc_selection,
      .new_divider_selection, .fast_internal_frequency, .external_osc_mode,
      .pll_enable, .ext_osc_enable, .osc_cfg_reserved,
      .fail_safe_monitor_enable, .secondary_fail_status, .primary_fail_status,
      .osc_fail_interrupt_flag, .clock_switch_allow, .priority_lock_bit,
      .second_oscillator_pin_out, .second_oscillator_pin_oe, .brownout_active,
      .brownout_trip_select);
   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // bytes must settle before release, so they change with reset low
   task automatic boot(input logic [7:0] b1, input logic [7:0] b2,
      input logic [7:0] b3);
      @(posedge core_clk);
      rst_n <= 1'b0;
      cfg_osc_byte <= b1;
      cfg_mon_byte <= b2;
      cfg_rst_byte <= b3;
      cyc(8);
      rst_n <= 1'b1;
      cyc(6);
   endtask
   task automatic sw_write(input logic [2:0] o, input logic [3:0] d);
      @(posedge core_clk);
      {sw_new_osc_wr, sw_new_div_wr} <= 2'h3;
      sw_new_osc_data <= o;
      sw_new_div_data <= d;
      @(posedge core_clk);
      {sw_new_osc_wr, sw_new_div_wr} <= 2'h0;
      @(negedge core_clk);
   endtask
   task automatic lk(input logic cl, input logic st);
      @(posedge core_clk);
      {sw_lock_clear, sw_lock_set} <= {cl, st};
      @(posedge core_clk);
      {sw_lock_clear, sw_lock_set} <= 2'h0;
      @(negedge core_clk);
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   // both fields walk every code; clock out requested throughout
   task automatic t_osc();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         boot({1'b1, c, 1'b1, c}, 8'hee, 8'h7f);
         @(negedge core_clk);
         check(current_osc_selection, (c == 3'h6 || c == 3'h0) ? 3'h6 : c);
         check(external_osc_mode, c);
         check(pll_enable, c == 3'h2);
         check(ext_osc_enable, c == 3'h7 || c == 3'h2);
         check(osc_cfg_reserved, c == 3'h1 || c == 3'h3);
         check(second_oscillator_pin_oe, c > 3'h2);
         if (c == 3'h6 || c == 3'h0) begin
            check(new_osc_selection, 3'h6);
            check(fast_internal_frequency,
               c[1] ? `CCFG_FREQ_4MHZ : `CCFG_FREQ_64MHZ);
            check(new_divider_selection, c[1] ? `CCFG_DIV_4 : `CCFG_DIV_1);
         end
      end
      $display("oscillator decode test ended");
   endtask
   task automatic t_switch();
      boot(8'hee, 8'hee, 8'h7f);
      sw_write(3'h5, 4'h3);
      check(new_osc_selection, 3'h5);
      check(new_divider_selection, 4'h3);
      boot(8'hee, 8'he6, 8'h7f);
      sw_write(3'h5, 4'h3);
      check(new_osc_selection, 3'h6);
      check(new_divider_selection, `CCFG_DIV_4);
      $display("clock switch test ended");
   endtask
   task automatic t_fail(input logic [7:0] mb);
      boot(8'hee, mb, 8'h7f);
      @(posedge core_clk);
      {secondary_fail_event, primary_fail_event} <= 2'h3;
      cyc(4);
      @(negedge core_clk);
      check(secondary_fail_status, mb[7] & mb[5]);
      check(primary_fail_status, mb[6] & mb[5]);
      check(osc_fail_interrupt_flag, mb[5] & (mb[7] | mb[6]));
      @(posedge core_clk);
      {secondary_fail_event, primary_fail_event} <= 2'h0;
      cyc(3);
      sw_fail_clear <= 1'b1;
      @(posedge core_clk);
      sw_fail_clear <= 1'b0;
      @(negedge core_clk);
      check(osc_fail_interrupt_flag, 1'b0);
      check(secondary_fail_status, 1'b0);
      check(primary_fail_status, 1'b0);
      $display("fail monitor test ended");
   endtask
   task automatic t_lock(input logic one);
      boot(8'hee, {6'h3b, one, 1'b0}, 8'h7f);
      lk(1'b1, 1'b0);
      check(priority_lock_bit, 1'b0);
      lk(1'b0, 1'b1);
      check(priority_lock_bit, 1'b1);
      lk(1'b1, 1'b0);
      check(priority_lock_bit, one);
      $display("priority lock test ended");
   endtask
   task automatic t_bor();
      logic e;
      logic [1:0] v;
      for (int m = 0; m < 4; m++) begin
         v = m[1:0] ^ 2'h2;
         @(posedge core_clk);
         brownout_voltage_select <= v;
         boot(8'hee, 8'hee, {m[1:0], 6'h3f});
         for (int j = 0; j < 4; j++) begin
            @(posedge core_clk);
            {sleep_active, software_brownout_enable} <= j[1:0];
            // trip select is frozen at reset; later pin moves are ignored
            brownout_voltage_select <= j[1:0];
            cyc(4);
            @(negedge core_clk);
            e = m == 3 || (m == 2 && !j[1]) || (m == 1 && j[0]);
            check(brownout_active, e);
            if (e)
               check(brownout_trip_select, v);
         end
      end
      $display("brown-out test ended");
   endtask
   // bytes change after capture; decoded settings must not follow
   task automatic t_hold();
      boot(8'hee, 8'hee, 8'hff);
      @(posedge core_clk);
      {cfg_osc_byte, cfg_mon_byte} <= 16'h0000;
      cyc(6);
      @(negedge core_clk);
      check(current_osc_selection, 3'h6);
      check(external_osc_mode, 3'h6);
      check(clock_switch_allow, 1'b1);
      check(fail_safe_monitor_enable, 1'b1);
      $display("hold test ended");
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // the run needs under a thousand cycles; this allows five times that
   initial begin
      #500000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      {rst_n, secondary_fail_event, primary_fail_event, sleep_active} = '0;
      {software_brownout_enable, sw_new_osc_wr, sw_new_div_wr} = '0;
      {sw_lock_clear, sw_lock_set, sw_fail_clear} = '0;
      {sw_new_osc_data, sw_new_div_data, brownout_voltage_select} = '0;
      {cfg_osc_byte, cfg_mon_byte, cfg_rst_byte} = 24'hffff7f;
      cyc(8);
      t_osc();
      t_switch();
      t_fail(8'hee);
      t_fail(8'h6e);
      t_fail(8'hae);
      t_fail(8'hce);
      t_lock(1'b1);
      t_lock(1'b0);
      t_bor();
      t_hold();
      report_and_stop();
   end
endmodule
